// [hw/pcie_capability_header_regs.sv]
// express capability header and device capabilities registers of a switch port
// assumes an apb4 master on pclk, straps from pins, power-limit messages from the
// link layer on pclk as a one-cycle strobe with value and scale
`timescale 1ns/1ns
module pcie_capability_header_regs (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [capreg_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // straps from pins
  input wire logic strap_upstream,
  input wire logic strap_compat_1p1,
  // power-limit message from the link layer
  input wire logic spl_valid,
  input wire logic [7:0] spl_value,
  input wire logic [1:0] spl_scale,
  // derived limit
  output logic [capreg_pkg::MW_W-1:0] slot_power_mw
);

  // ==========================================================================
  // strap synchronisers
  logic [2:0] up_sync_r;
  logic [2:0] up_sync_nxt;
  logic [2:0] cm_sync_r;
  logic [2:0] cm_sync_nxt;
  logic up_stable_r;
  logic up_stable_nxt;
  logic cm_stable_r;
  logic cm_stable_nxt;

  always_comb begin
    up_sync_nxt = {up_sync_r[1:0], strap_upstream};
    cm_sync_nxt = {cm_sync_r[1:0], strap_compat_1p1};
    // stage 0 feeds stage 1 only; stages 1 and 2 must agree
    up_stable_nxt = (up_sync_r[1] == up_sync_r[2]) ? up_sync_r[2] : up_stable_r;
    cm_stable_nxt = (cm_sync_r[1] == cm_sync_r[2]) ? cm_sync_r[2] : cm_stable_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_sync_r <= '0;
      cm_sync_r <= '0;
      up_stable_r <= 1'b0;
      cm_stable_r <= 1'b0;
    end else begin
      up_sync_r <= up_sync_nxt;
      cm_sync_r <= cm_sync_nxt;
      up_stable_r <= up_stable_nxt;
      cm_stable_r <= cm_stable_nxt;
    end
  end

  // ==========================================================================
  // startup: straps are caught once, then mode dependent defaults load
  capreg_pkg::init_state_e state_r;
  capreg_pkg::init_state_e state_nxt;
  logic [2:0] wait_r;
  logic [2:0] wait_nxt;
  logic upstream_r;
  logic upstream_nxt;
  logic compat_r;
  logic compat_nxt;
  logic load_defaults;

  always_comb begin
    state_nxt = state_r;
    wait_nxt = wait_r;
    upstream_nxt = upstream_r;
    compat_nxt = compat_r;
    load_defaults = 1'b0;
    unique case (state_r)
      capreg_pkg::ST_WAIT: begin
        if (wait_r == capreg_pkg::STRAP_WAIT) begin
          state_nxt = capreg_pkg::ST_RUN;
          upstream_nxt = up_stable_r;
          compat_nxt = cm_stable_r;
          load_defaults = 1'b1;
        end else begin
          wait_nxt = wait_r + 3'h1;
        end
      end
      capreg_pkg::ST_RUN: begin
        state_nxt = capreg_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= capreg_pkg::ST_WAIT;
      wait_r <= '0;
      upstream_r <= 1'b0;
      compat_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      wait_r <= wait_nxt;
      upstream_r <= upstream_nxt;
      compat_r <= compat_nxt;
    end
  end

  wire logic running = (state_r == capreg_pkg::ST_RUN);

  // ==========================================================================
  // writable bits and captured power limit
  logic [31:0] hdr_rw_r;
  logic [31:0] hdr_rw_nxt;
  logic [31:0] dcap_rw_r;
  logic [31:0] dcap_rw_nxt;
  logic [7:0] cplv_r;
  logic [7:0] cplv_nxt;
  logic [1:0] cpls_r;
  logic [1:0] cpls_nxt;
  logic [31:0] byte_mask;
  logic [31:0] hdr_defaults;
  logic [31:0] dcap_defaults;
  logic hdr_sel;
  logic dcap_sel;
  logic wr_fire;

  always_comb begin
    byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    hdr_sel = (paddr == capreg_pkg::HDR_OFS);
    dcap_sel = (paddr == capreg_pkg::DCAP_OFS);
    wr_fire = psel && penable && pready && pwrite;
    hdr_defaults = '0;
    hdr_defaults[capreg_pkg::NXTP_LSB +: 8] = capreg_pkg::NXTP_RST;
    hdr_defaults[capreg_pkg::VERSION_LSB +: 4] = capreg_pkg::VERSION_RST;
    hdr_defaults[capreg_pkg::SLOT_BIT] = capreg_pkg::SLOT_RST;
    hdr_defaults[capreg_pkg::TCR_BIT] = compat_nxt ? capreg_pkg::TCR_RST_COMPAT
                                                   : capreg_pkg::TCR_RST;
    dcap_defaults = '0;
    dcap_defaults[capreg_pkg::MPS_LSB +: 3] = capreg_pkg::MPS_RST;
    dcap_defaults[capreg_pkg::XTAG_BIT] = capreg_pkg::XTAG_RST;
    hdr_rw_nxt = hdr_rw_r;
    dcap_rw_nxt = dcap_rw_r;
    cplv_nxt = cplv_r;
    cpls_nxt = cpls_r;
    if (load_defaults) begin
      hdr_rw_nxt = hdr_defaults;
      dcap_rw_nxt = dcap_defaults;
      cplv_nxt = '0;
      cpls_nxt = '0;
    end else if (running) begin
      // only the writable positions of lanes that are strobed change
      if (wr_fire && hdr_sel) begin
        hdr_rw_nxt = (hdr_rw_r & ~(capreg_pkg::HDR_WMASK & byte_mask)) |
                     (pwdata & capreg_pkg::HDR_WMASK & byte_mask);
      end
      if (wr_fire && dcap_sel) begin
        dcap_rw_nxt = (dcap_rw_r & ~(capreg_pkg::DCAP_WMASK & byte_mask)) |
                      (pwdata & capreg_pkg::DCAP_WMASK & byte_mask);
      end
      if (spl_valid && upstream_r) begin
        cplv_nxt = spl_value;
        cpls_nxt = spl_scale;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hdr_rw_r <= '0;
      dcap_rw_r <= '0;
      cplv_r <= '0;
      cpls_r <= '0;
    end else begin
      hdr_rw_r <= hdr_rw_nxt;
      dcap_rw_r <= dcap_rw_nxt;
      cplv_r <= cplv_nxt;
      cpls_r <= cpls_nxt;
    end
  end

  // ==========================================================================
  // read words
  logic [31:0] hdr_word;
  logic [31:0] dcap_word;

  always_comb begin
    hdr_word = hdr_rw_r & capreg_pkg::HDR_WMASK;
    hdr_word[capreg_pkg::CAP_ID_LSB +: 8] = capreg_pkg::CAP_ID_VAL;
    hdr_word[capreg_pkg::KIND_LSB +: 4] = upstream_r ? capreg_pkg::KIND_UP
                                                     : capreg_pkg::KIND_DOWN;
    hdr_word[capreg_pkg::IMI_LSB +: 5] = capreg_pkg::IMI_VAL;
    dcap_word = dcap_rw_r & capreg_pkg::DCAP_WMASK;
    dcap_word[capreg_pkg::PHANTOM_LSB +: 2] = 2'h0;
    dcap_word[capreg_pkg::L0S_LSB +: 3] = 3'h0;
    dcap_word[capreg_pkg::L1_LSB +: 3] = 3'h0;
    dcap_word[capreg_pkg::ABTN_BIT] = 1'b0;
    dcap_word[capreg_pkg::AIND_BIT] = 1'b0;
    dcap_word[capreg_pkg::PIND_BIT] = 1'b0;
    dcap_word[capreg_pkg::RBE_BIT] = capreg_pkg::RBE_VAL;
    // downstream capture registers never load, so these read zero there
    dcap_word[capreg_pkg::CPLV_LSB +: 8] = cplv_r;
    dcap_word[capreg_pkg::CPLS_LSB +: 2] = cpls_r;
  end

  // ==========================================================================
  // apb answer: read data refreshed every selected cycle, so the access
  // phase always shows the value after any write of the previous transfer
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic err_r;
  logic err_nxt;
  logic fresh_r;
  logic fresh_nxt;

  always_comb begin
    rdata_nxt = rdata_r;
    err_nxt = err_r;
    fresh_nxt = psel && running;
    if (psel) begin
      rdata_nxt = hdr_sel ? hdr_word : (dcap_sel ? dcap_word : 32'h00000000);
      err_nxt = !(hdr_sel || dcap_sel);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= '0;
      err_r <= 1'b0;
      fresh_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      err_r <= err_nxt;
      fresh_r <= fresh_nxt;
    end
  end

  // stalls accesses during startup; one setup cycle in run is enough
  assign pready = penable && running && fresh_r;
  assign prdata = (pready && !pwrite) ? rdata_r : 32'h00000000;
  assign pslverr = pready && err_r;

  // ==========================================================================
  // power limit in milliwatts
  power_limit_calc u_calc (
    .pclk(pclk),
    .presetn(presetn),
    .limit_value(cplv_r),
    .limit_scale(cpls_r),
    .limit_mw(slot_power_mw)
  );

  // ==========================================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence hdr_read_done;
    psel && penable && pready && !pwrite && hdr_sel;
  endsequence

  sequence hdr_write_done;
    psel && penable && pready && pwrite && hdr_sel;
  endsequence

  sequence dcap_write_done;
    psel && penable && pready && pwrite && dcap_sel;
  endsequence

  cap_id_read_a: assert property (hdr_read_done |-> prdata[7:0] == 8'h10)
    else $error("capability identifier not 0x10");

  next_ptr_init_a: assert property ($rose(running) |-> hdr_word[15:8] == 8'hc0)
    else $error("next pointer default wrong");

  version_init_a: assert property ($rose(running) |-> hdr_word[19:16] == 4'h1)
    else $error("version default wrong");

  port_kind_a: assert property (running |->
    hdr_word[23:20] == (upstream_r ? 4'h5 : 4'h6))
    else $error("port kind does not match strap");

  slot_init_a: assert property ($rose(running) |-> !hdr_word[24])
    else $error("slot flag not zero after startup");

  msg_index_a: assert property (hdr_word[29:25] == 5'h00 && !hdr_word[31])
    else $error("message index or reserved bit not zero");

  tcr_mode_a: assert property ($rose(running) |-> hdr_word[30] == !compat_r)
    else $error("traffic class flag default wrong for mode");

  payload_init_a: assert property ($rose(running) |->
    dcap_word[2:0] == 3'h4 && dcap_word[5])
    else $error("payload or extended tag default wrong");

  fixed_dcap_a: assert property (dcap_word[17:6] == 12'h200 &&
    dcap_word[4:3] == 2'h0 && dcap_word[31:28] == 4'h0)
    else $error("fixed device capability bits wrong");

  capture_up_a: assert property (running && upstream_r && spl_valid |=>
    dcap_word[25:18] == $past(spl_value) && dcap_word[27:26] == $past(spl_scale))
    else $error("power limit not captured");

  down_zero_a: assert property (!upstream_r |-> dcap_word[27:18] == 10'h000)
    else $error("downstream power limit not zero");

  ro_write_a: assert property (hdr_write_done |=>
    hdr_word[7:0] == 8'h10 && hdr_word[29:25] == 5'h00 && !hdr_word[31] &&
    $stable(hdr_word[23:20]))
    else $error("write disturbed fixed header bits");

  ready_bound_a: assert property (psel && !penable && running |=> pready)
    else $error("access phase not answered in one cycle");

  dcap_fixed_write_a: assert property (dcap_write_done |=>
    dcap_word[4:3] == 2'h0 && dcap_word[15:6] == 10'h200 && dcap_word[31:28] == 4'h0)
    else $error("write disturbed fixed device capability bits");

  unmapped_err_a: assert property (psel && penable && pready &&
    !(hdr_sel || dcap_sel) |-> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");

  next_ptr_write_a: assert property (psel && penable && pready && pwrite && hdr_sel &&
    pstrb[1] |=> hdr_word[15:8] == $past(pwdata[15:8]))
    else $error("next pointer write not taken");

endmodule

// [inc/capreg_pkg.sv]
// constants for the express capability header and device capabilities registers
// assumes a 32-bit apb register bus with byte addresses
package capreg_pkg;

  // ==========================================================================
  // register map
  localparam logic [11:0] HDR_OFS = 12'h040;
  localparam logic [11:0] DCAP_OFS = 12'h044;
  localparam int ADDR_W = 12;

  // ==========================================================================
  // header field positions
  localparam int CAP_ID_LSB = 0;
  localparam int NXTP_LSB = 8;
  localparam int VERSION_LSB = 16;
  localparam int KIND_LSB = 20;
  localparam int SLOT_BIT = 24;
  localparam int IMI_LSB = 25;
  localparam int TCR_BIT = 30;

  // header constants and reset values
  localparam logic [7:0] CAP_ID_VAL = 8'h10;
  localparam logic [7:0] NXTP_RST = 8'hc0;
  localparam logic [3:0] VERSION_RST = 4'h1;
  localparam logic [3:0] KIND_UP = 4'h5;
  localparam logic [3:0] KIND_DOWN = 4'h6;
  localparam logic [4:0] IMI_VAL = 5'h00;
  localparam logic SLOT_RST = 1'b0;
  localparam logic TCR_RST = 1'b1;
  localparam logic TCR_RST_COMPAT = 1'b0;
  localparam logic [31:0] HDR_WMASK = 32'h410fff00;

  // ==========================================================================
  // device capabilities field positions
  localparam int MPS_LSB = 0;
  localparam int PHANTOM_LSB = 3;
  localparam int XTAG_BIT = 5;
  localparam int L0S_LSB = 6;
  localparam int L1_LSB = 9;
  localparam int ABTN_BIT = 12;
  localparam int AIND_BIT = 13;
  localparam int PIND_BIT = 14;
  localparam int RBE_BIT = 15;
  localparam int CPLV_LSB = 18;
  localparam int CPLS_LSB = 26;

  // device capabilities constants and reset values
  localparam logic [2:0] MPS_RST = 3'h4;
  localparam logic XTAG_RST = 1'b1;
  localparam logic RBE_VAL = 1'b1;
  localparam logic [31:0] DCAP_WMASK = 32'h00000027;

  // ==========================================================================
  // power limit scale codes and milliwatt multipliers
  localparam logic [1:0] SCALE_X1 = 2'h0;
  localparam logic [1:0] SCALE_X0P1 = 2'h1;
  localparam logic [1:0] SCALE_X0P01 = 2'h2;
  localparam logic [1:0] SCALE_X0P001 = 2'h3;
  localparam logic [9:0] MW_X1 = 10'h3e8;
  localparam logic [9:0] MW_X0P1 = 10'h064;
  localparam logic [9:0] MW_X0P01 = 10'h00a;
  localparam logic [9:0] MW_X0P001 = 10'h001;
  localparam int MW_W = 18;

  // ==========================================================================
  // startup: cycles until the strap synchronisers hold settled values
  localparam logic [2:0] STRAP_WAIT = 3'h4;

  typedef enum logic [0:0] {
    ST_WAIT = 1'b0,
    ST_RUN = 1'b1
  } init_state_e;

endpackage

// [hw/power_limit_calc.sv]
// converts the captured slot power limit value and scale into milliwatts
// assumes value and scale are registers on the same clock
`timescale 1ns/1ns
module power_limit_calc (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // captured limit
  input wire logic [7:0] limit_value,
  input wire logic [1:0] limit_scale,
  // result
  output logic [capreg_pkg::MW_W-1:0] limit_mw
);

  logic [capreg_pkg::MW_W-1:0] mw_r;
  logic [capreg_pkg::MW_W-1:0] mw_nxt;
  logic [9:0] mult;

  // ==========================================================================
  // scale to multiplier
  always_comb begin
    unique case (limit_scale)
      capreg_pkg::SCALE_X1: mult = capreg_pkg::MW_X1;
      capreg_pkg::SCALE_X0P1: mult = capreg_pkg::MW_X0P1;
      capreg_pkg::SCALE_X0P01: mult = capreg_pkg::MW_X0P01;
      capreg_pkg::SCALE_X0P001: mult = capreg_pkg::MW_X0P001;
    endcase
    // 255 * 1000 fits in 18 bits
    // operands widened first: a product at the 10-bit operand width would wrap
    mw_nxt = capreg_pkg::MW_W'(limit_value) * capreg_pkg::MW_W'(mult);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mw_r <= '0;
    end else begin
      mw_r <= mw_nxt;
    end
  end

  assign limit_mw = mw_r;

  // ==========================================================================
  // checks
  scale_mw_a: assert property (@(posedge pclk) disable iff (!presetn)
    (limit_scale == capreg_pkg::SCALE_X0P01) |=>
      (limit_mw == capreg_pkg::MW_W'($past(limit_value) * 10)))
    else $error("milliwatt result wrong for scale 0.01");

endmodule

// [sim/power_msg_source.sv]
// link partner model: sends power-limit messages as one-cycle strobes
// assumes the port samples the strobe on the rising edge of pclk
`timescale 1ns/1ns
module power_msg_source (
  // clock
  input wire logic pclk,
  // message towards the port
  output logic spl_valid,
  output logic [7:0] spl_value,
  output logic [1:0] spl_scale
);
  initial begin
    spl_valid = 1'b0;
    spl_value = 8'h00;
    spl_scale = 2'h0;
  end

  // ==========================================================================
  // message driving
  // value and scale always travel together with the strobe
  task automatic send(input logic [7:0] v, input logic [1:0] s);
    @(posedge pclk);
    spl_valid <= 1'b1;
    spl_value <= v;
    spl_scale <= s;
  endtask

  // payload means nothing outside the strobe, so it is scrambled
  task automatic idle();
    @(posedge pclk);
    spl_valid <= 1'b0;
    spl_value <= ~spl_value;
    spl_scale <= ~spl_scale;
  endtask
endmodule

// [sim/test_pcie_capability_header_regs.sv]
// self-checking bench for the capability header register block
// assumes the partner model drives the power-limit strobe
`timescale 1ns/1ns
module test_pcie_capability_header_regs;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic strap_upstream, strap_compat_1p1, spl_valid;
  logic [7:0] spl_value;
  logic [1:0] spl_scale;
  logic [capreg_pkg::MW_W-1:0] slot_power_mw;
  logic up, cp;
  int err_count = 0;
  int tests_run = 0;

  always #10 pclk = ~pclk;

  pcie_capability_header_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .strap_upstream(strap_upstream),
    .strap_compat_1p1(strap_compat_1p1), .spl_valid(spl_valid), .spl_value(spl_value),
    .spl_scale(spl_scale), .slot_power_mw(slot_power_mw));

  power_msg_source src (.pclk(pclk), .spl_valid(spl_valid), .spl_value(spl_value),
    .spl_scale(spl_scale));

  // ==========================================================================
  // checks and verdict
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge pclk);
    err_count++;
    complete_run();
  end

  // ==========================================================================
  // expectations
  function automatic logic [31:0] hdr_rst(input logic u, input logic c);
    return {1'b0, ~c, 5'h00, 1'b0, (u ? 4'h5 : 4'h6), 4'h1, 8'hc0, 8'h10};
  endfunction

  // only strobed lanes of writable bits change
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
    input logic [3:0] s, input logic [31:0] m);
    logic [31:0] eff;
    eff = m & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (old & ~eff) | (d & eff);
  endfunction

  function automatic logic [31:0] mult(input logic [1:0] s);
    case (s)
      2'h0: return 32'd1000;
      2'h1: return 32'd100;
      2'h2: return 32'd10;
      default: return 32'd1;
    endcase
  endfunction

  // ==========================================================================
  // apb master: answer taken at the edge where pready is high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // read at the edge, before its updates land: values of the ending cycle
    @(posedge pclk);
    while (pready !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 40) begin
      chk("pready wait", 32'h1, 32'h0);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    strap_upstream <= up;
    strap_compat_1p1 <= cp;
    repeat (16) @(posedge pclk);
    @(negedge pclk);
    chk("reset ready", 32'h0, {31'h0, pready});
    chk("reset mw", 32'h0, 32'(slot_power_mw));
    @(posedge pclk);
    presetn <= 1'b1;
    // a message during startup must be dropped
    src.send(8'h5a, 2'h1);
    src.idle();
  endtask

  // ==========================================================================
  // scenarios of one strap setting
  task automatic run_mode();
    logic [31:0] rd, d, hs, ds, r;
    logic er;
    logic [3:0] s;
    logic [11:0] a;
    logic [7:0] v;
    hs = hdr_rst(up, cp);
    ds = 32'h00008024;
    apb(1'b0, 12'h040, 32'h0, 4'h0, rd, er);
    chk("header reset", hs, rd);
    apb(1'b0, 12'h044, 32'h0, 4'h0, rd, er);
    chk("devcap reset", ds, rd);
    for (int i = 0; i < 10; i++) begin
      d = $urandom;
      r = $urandom;
      s = (i < 2) ? 4'hf : r[3:0];
      a = i[0] ? 12'h044 : 12'h040;
      if (up) d[24] = 1'b0;
      apb(1'b1, a, d, s, rd, er);
      chk("write err", 32'h0, {31'h0, er});
      if (i[0]) ds = merge(ds, d, s, 32'h00000027);
      else hs = merge(hs, d, s, 32'h410fff00);
      apb(1'b0, a, 32'h0, 4'h0, rd, er);
      chk("readback", i[0] ? ds : hs, rd);
    end
    for (int k = 0; k < 3; k++) begin
      a = (k == 0) ? 12'h048 : ((k == 1) ? 12'h03c : 12'h840);
      apb(1'b1, a, 32'hffffffff, 4'hf, rd, er);
      chk("unmapped write err", 32'h1, {31'h0, er});
      apb(1'b0, a, 32'h0, 4'h0, rd, er);
      chk("unmapped read err", 32'h1, {31'h0, er});
      chk("unmapped data", 32'h0, rd);
    end
    apb(1'b0, 12'h040, 32'h0, 4'h0, rd, er);
    chk("header kept", hs, rd);
    for (int sc = 0; sc < 4; sc++) begin
      r = $urandom;
      v = r[7:0];
      src.send(r[15:8], ~sc[1:0]);
      src.send(v, sc[1:0]);
      src.idle();
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk("power mw", up ? 32'(v) * mult(sc[1:0]) : 32'h0, 32'(slot_power_mw));
      apb(1'b0, 12'h044, 32'h0, 4'h0, rd, er);
      chk("captured limit", up ? (ds | {4'h0, sc[1:0], v, 18'h0}) : ds, rd);
    end
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    strap_upstream = 1'b1;
    strap_compat_1p1 = 1'b0;
    void'($urandom(60174));
    for (int m = 0; m < 3; m++) begin
      up = (m != 1);
      cp = (m == 2);
      do_reset();
      run_mode();
    end
    complete_run();
  end
endmodule
